//--- logic/rmpl_master_end.sv
// master end: sends measurement polls and checks the sensor's reply
`timescale 1ns/1ps
module rmpl_master_end #(
  parameter int TIMEOUT_BITS = rmpl_pkg::POLL_BITS
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // shared line
  rmpl_if.master_mp link,
  // configuration
  input wire logic [11:0] baud_div_in,
  // poll request
  input wire logic poll_req_in,
  input wire logic [7:0] target_in,
  input wire logic [7:0] source_in,
  output logic poll_ready_out,
  // poll answer
  output logic [31:0] raw_out,
  output logic [31:0] scaled_out,
  output logic rsp_valid_out,
  output logic rsp_err_out,
  output logic timeout_out
);

  typedef enum logic [1:0] {
    RMPL_M_IDLE = 2'b00,
    RMPL_M_SEND = 2'b01,
    RMPL_M_WAIT = 2'b11
  } rmpl_mstate_e;

  rmpl_mstate_e state_r;
  logic [11:0] div_w;
  logic line_s1_r;
  logic line_s2_r;
  logic [11:0] tick_cnt_r;
  logic tick_w;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_bits_r;
  logic tx_load_w;
  logic [7:0] tx_byte_w;
  logic [4:0] idx_r;
  logic [7:0] tgt_r;
  logic [7:0] src_r;
  logic [7:0] sum_r;
  logic oe_r;
  logic [11:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_stb_r;
  logic [7:0] expect_w;
  logic bad_r;
  logic [63:0] data_r;
  logic [12:0] wait_r;

  ////////////////////////////////////////////////////////////////////////
  assign div_w = (baud_div_in < rmpl_pkg::DIV_MIN || baud_div_in > rmpl_pkg::DIV_MAX) ?
                 rmpl_pkg::DIV_DEFAULT : baud_div_in;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_s1_r <= 1'b1;
      line_s2_r <= 1'b1;
    end else begin
      line_s1_r <= link.line;
      line_s2_r <= line_s1_r;
    end
  end

  // bit-rate enable, also paces the reply timeout
  assign tick_w = (tick_cnt_r == 12'h000);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= 12'h000;
    end else if (tx_load_w || tick_w) begin
      tick_cnt_r <= div_w - 12'h001;
    end else begin
      tick_cnt_r <= tick_cnt_r - 12'h001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_r <= 10'h3ff;
      tx_bits_r <= 4'h0;
    end else if (tx_load_w) begin
      tx_sh_r <= {1'b1, tx_byte_w, 1'b0};
      tx_bits_r <= rmpl_pkg::UART_BITS;
    end else if (tx_bits_r != 4'h0 && tick_w) begin
      tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      tx_bits_r <= tx_bits_r - 4'h1;
    end
  end

  assign link.mst_tx = tx_sh_r[0];
  assign link.mst_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////
  // receiver listens only while a reply is awaited
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_cnt_r <= 12'h000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_stb_r <= 1'b0;
    end else begin
      rx_stb_r <= 1'b0;
      if (rx_bit_r == 4'h0) begin
        if (!line_s2_r && state_r == RMPL_M_WAIT) begin
          rx_cnt_r <= div_w >> 1;
          rx_bit_r <= 4'h1;
        end
      end else if (rx_cnt_r != 12'h000) begin
        rx_cnt_r <= rx_cnt_r - 12'h001;
      end else begin
        rx_cnt_r <= div_w - 12'h001;
        if (rx_bit_r == 4'h1) begin
          rx_bit_r <= line_s2_r ? 4'h0 : 4'h2;
        end else if (rx_bit_r < rmpl_pkg::UART_BITS) begin
          rx_sh_r <= {line_s2_r, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 4'h1;
        end else begin
          rx_bit_r <= 4'h0;
          rx_stb_r <= line_s2_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request bytes in wire order
  always_comb begin
    case (idx_r)
      5'd0: tx_byte_w = rmpl_pkg::REQ_START;
      5'd1: tx_byte_w = tgt_r;
      5'd2: tx_byte_w = src_r;
      5'd3: tx_byte_w = rmpl_pkg::FUNC_MEAS;
      5'd4: tx_byte_w = sum_r;
      default: tx_byte_w = rmpl_pkg::FRAME_END;
    endcase
  end

  // fixed reply bytes and the running sum; data positions are not compared here
  always_comb begin
    case (idx_r)
      5'd0, 5'd3: expect_w = rmpl_pkg::RSP_HDR;
      5'd1, 5'd2: expect_w = rmpl_pkg::RSP_LEN;
      rmpl_pkg::RSP_REQ_ADDR: expect_w = src_r;
      rmpl_pkg::RSP_OWN_ADDR: expect_w = tgt_r;
      rmpl_pkg::RSP_CTRL_POS: expect_w = rmpl_pkg::RSP_CTRL;
      rmpl_pkg::RSP_SUM: expect_w = sum_r;
      default: expect_w = rmpl_pkg::FRAME_END;
    endcase
  end

  assign tx_load_w = (state_r == RMPL_M_SEND) && (tx_bits_r == 4'h0) &&
                     (idx_r < rmpl_pkg::REQ_BYTES);
  assign poll_ready_out = (state_r == RMPL_M_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // poll sequencing: send, release the line, collect or time out
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= RMPL_M_IDLE;
      oe_r <= 1'b0;
      idx_r <= 5'd0;
      tgt_r <= rmpl_pkg::STATION_DEFAULT;
      src_r <= 8'h00;
      sum_r <= 8'h00;
      bad_r <= 1'b0;
      data_r <= 64'h0;
      wait_r <= 13'd0;
      raw_out <= 32'h0000_0000;
      scaled_out <= 32'h0000_0000;
      rsp_valid_out <= 1'b0;
      rsp_err_out <= 1'b0;
      timeout_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      rsp_err_out <= 1'b0;
      timeout_out <= 1'b0;
      case (state_r)
        RMPL_M_IDLE: begin
          if (poll_req_in) begin
            tgt_r <= target_in;
            src_r <= source_in;
            sum_r <= target_in + source_in + rmpl_pkg::FUNC_MEAS;
            idx_r <= 5'd0;
            oe_r <= 1'b1;
            state_r <= RMPL_M_SEND;
          end
        end
        RMPL_M_SEND: begin
          if (tx_load_w) begin
            idx_r <= idx_r + 5'd1;
          end else if (tx_bits_r == 4'h0) begin
            oe_r <= 1'b0;
            idx_r <= 5'd0;
            sum_r <= 8'h00;
            bad_r <= 1'b0;
            wait_r <= 13'd0;
            state_r <= RMPL_M_WAIT;
          end
        end
        RMPL_M_WAIT: begin
          if (tick_w) begin
            wait_r <= wait_r + 13'd1;
          end
          if (rx_stb_r) begin
            idx_r <= idx_r + 5'd1;
            if (idx_r >= rmpl_pkg::RSP_REQ_ADDR && idx_r < rmpl_pkg::RSP_SUM) begin
              sum_r <= sum_r + rx_sh_r;
            end
            if (idx_r >= rmpl_pkg::RSP_RAW0 && idx_r < rmpl_pkg::RSP_SUM) begin
              data_r <= {rx_sh_r, data_r[63:8]};
            end else if (rx_sh_r != expect_w) begin
              bad_r <= 1'b1;
            end
            if (idx_r == rmpl_pkg::RSP_END) begin
              state_r <= RMPL_M_IDLE;
              if (bad_r || rx_sh_r != rmpl_pkg::FRAME_END) begin
                rsp_err_out <= 1'b1;
              end else begin
                raw_out <= data_r[31:0];
                scaled_out <= data_r[63:32];
                rsp_valid_out <= 1'b1;
              end
            end
          end else if (wait_r >= 13'(TIMEOUT_BITS)) begin
            timeout_out <= 1'b1;
            state_r <= RMPL_M_IDLE;
          end
        end
        default: begin
          state_r <= RMPL_M_IDLE;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- logic/rmpl_sensor_end.sv
// sensor end: answers addressed measurement polls on the shared line
`timescale 1ns/1ps

// Notes on behaviour
// - default 256000 baud, range 9600 to 256000
// - half duplex; multibyte fields least byte first
// - station address 126 default, settable 2..126
// - request: 10, target, source, 4c, sum, 16
// - request sum covers target, source, function
// - unscaled float in reply bytes 8..11
// - scaled float bytes 12..15, zero if unscaled
// - reply sum covers bytes 5 through 15
// - one poll takes about 0.9 ms at 256000 baud (60 request bits, 2 turnaround, 170 reply bits)
// - factory default delivers scaled measurements
module rmpl_sensor_end (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // shared line
  rmpl_if.sensor_mp link,
  // configuration
  input wire logic [11:0] baud_div_in,
  input wire logic [7:0] station_in,
  input wire logic scale_set_in,
  // measurements
  input wire logic [31:0] raw_value_in,
  input wire logic [31:0] scaled_value_in,
  // status
  output logic poll_served_out,
  output logic sum_err_out,
  output logic busy_out
);

  typedef enum logic [1:0] {
    RMPL_S_LISTEN = 2'b00,
    RMPL_S_TURN = 2'b01,
    RMPL_S_TALK = 2'b11
  } rmpl_sstate_e;

  rmpl_sstate_e state_r;
  logic [11:0] div_w, tick_cnt_r, rx_cnt_r;
  logic [7:0] own_w, tx_byte_w, tx_sum_r, rx_sh_r, req_sum_r, src_r, own_r;
  logic line_s1_r, line_s2_r, tick_w, tx_load_w, oe_r, rx_stb_r;
  logic addr_ok_r, func_ok_r, sum_ok_r, accept_w;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_bits_r, rx_bit_r;
  logic [4:0] tx_idx_r;
  logic [1:0] turn_r;
  logic [2:0] req_idx_r;
  logic [31:0] raw_r, scl_r;

  ////////////////////////////////////////////////////////////////////////
  // out-of-range settings fall back to the factory values
  assign div_w = (baud_div_in < rmpl_pkg::DIV_MIN || baud_div_in > rmpl_pkg::DIV_MAX) ?
                 rmpl_pkg::DIV_DEFAULT : baud_div_in;
  assign own_w = (station_in < rmpl_pkg::STATION_MIN || station_in > rmpl_pkg::STATION_MAX) ?
                 rmpl_pkg::STATION_DEFAULT : station_in;

  // line input crosses in from the pin
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_s1_r <= 1'b1;
      line_s2_r <= 1'b1;
    end else begin
      line_s1_r <= link.line;
      line_s2_r <= line_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit-rate enable; restarted on each byte load so the start bit is whole
  assign tick_w = (tick_cnt_r == 12'h000);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= 12'h000;
    end else if (tx_load_w || tick_w) begin
      tick_cnt_r <= div_w - 12'h001;
    end else begin
      tick_cnt_r <= tick_cnt_r - 12'h001;
    end
  end

  // transmit shifter, stop bits refill it so idle shows mark
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_r <= 10'h3ff;
      tx_bits_r <= 4'h0;
    end else if (tx_load_w) begin
      tx_sh_r <= {1'b1, tx_byte_w, 1'b0};
      tx_bits_r <= rmpl_pkg::UART_BITS;
    end else if (tx_bits_r != 4'h0 && tick_w) begin
      tx_sh_r <= {1'b1, tx_sh_r[9:1]};
      tx_bits_r <= tx_bits_r - 4'h1;
    end
  end

  assign link.dev_tx = tx_sh_r[0];
  assign link.dev_oe = oe_r;

  ////////////////////////////////////////////////////////////////////////
  // receiver: samples mid-bit; a framing error drops the byte
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_cnt_r <= 12'h000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_stb_r <= 1'b0;
    end else begin
      rx_stb_r <= 1'b0;
      if (rx_bit_r == 4'h0) begin
        if (!line_s2_r && state_r == RMPL_S_LISTEN) begin
          rx_cnt_r <= div_w >> 1;
          rx_bit_r <= 4'h1;
        end
      end else if (rx_cnt_r != 12'h000) begin
        rx_cnt_r <= rx_cnt_r - 12'h001;
      end else begin
        rx_cnt_r <= div_w - 12'h001;
        if (rx_bit_r == 4'h1) begin
          rx_bit_r <= line_s2_r ? 4'h0 : 4'h2;
        end else if (rx_bit_r < rmpl_pkg::UART_BITS) begin
          rx_sh_r <= {line_s2_r, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 4'h1;
        end else begin
          rx_bit_r <= 4'h0;
          rx_stb_r <= line_s2_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request parser; frames for other stations pass silently
  assign accept_w = rx_stb_r && req_idx_r == 3'd5 && rx_sh_r == rmpl_pkg::FRAME_END &&
                    addr_ok_r && func_ok_r && sum_ok_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_idx_r <= 3'd0;
      req_sum_r <= 8'h00;
      src_r <= 8'h00;
      addr_ok_r <= 1'b0;
      func_ok_r <= 1'b0;
      sum_ok_r <= 1'b0;
    end else if (rx_stb_r) begin
      case (req_idx_r)
        3'd0: req_idx_r <= (rx_sh_r == rmpl_pkg::REQ_START) ? 3'd1 : 3'd0;
        3'd1: begin
          addr_ok_r <= (rx_sh_r == own_w);
          req_sum_r <= rx_sh_r;
          req_idx_r <= 3'd2;
        end
        3'd2: begin
          src_r <= rx_sh_r;
          req_sum_r <= req_sum_r + rx_sh_r;
          req_idx_r <= 3'd3;
        end
        3'd3: begin
          func_ok_r <= (rx_sh_r == rmpl_pkg::FUNC_MEAS);
          req_sum_r <= req_sum_r + rx_sh_r;
          req_idx_r <= 3'd4;
        end
        3'd4: begin
          sum_ok_r <= (rx_sh_r == req_sum_r);
          req_idx_r <= 3'd5;
        end
        default: req_idx_r <= 3'd0;
      endcase
    end
  end

  // discarded addressed frame with a wrong sum
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sum_err_out <= 1'b0;
    end else begin
      sum_err_out <= rx_stb_r && req_idx_r == 3'd5 && rx_sh_r == rmpl_pkg::FRAME_END &&
                     addr_ok_r && func_ok_r && !sum_ok_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // values are frozen at acceptance so one reply is self-consistent
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      raw_r <= 32'h0000_0000;
      scl_r <= 32'h0000_0000;
      own_r <= rmpl_pkg::STATION_DEFAULT;
    end else if (accept_w) begin
      raw_r <= raw_value_in;
      scl_r <= scale_set_in ? scaled_value_in : 32'h0000_0000;
      own_r <= own_w;
    end
  end

  // reply byte for the current position
  always_comb begin
    case (tx_idx_r)
      5'd0, 5'd3: tx_byte_w = rmpl_pkg::RSP_HDR;
      5'd1, 5'd2: tx_byte_w = rmpl_pkg::RSP_LEN;
      rmpl_pkg::RSP_REQ_ADDR: tx_byte_w = src_r;
      rmpl_pkg::RSP_OWN_ADDR: tx_byte_w = own_r;
      rmpl_pkg::RSP_CTRL_POS: tx_byte_w = rmpl_pkg::RSP_CTRL;
      5'd7: tx_byte_w = raw_r[7:0];
      5'd8: tx_byte_w = raw_r[15:8];
      5'd9: tx_byte_w = raw_r[23:16];
      5'd10: tx_byte_w = raw_r[31:24];
      5'd11: tx_byte_w = scl_r[7:0];
      5'd12: tx_byte_w = scl_r[15:8];
      5'd13: tx_byte_w = scl_r[23:16];
      5'd14: tx_byte_w = scl_r[31:24];
      rmpl_pkg::RSP_SUM: tx_byte_w = tx_sum_r;
      default: tx_byte_w = rmpl_pkg::FRAME_END;
    endcase
  end

  assign tx_load_w = (state_r == RMPL_S_TALK) && (tx_bits_r == 4'h0) &&
                     (tx_idx_r < rmpl_pkg::RSP_BYTES);

  ////////////////////////////////////////////////////////////////////////
  // reply sequencing; the line is driven only while talking
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= RMPL_S_LISTEN;
      oe_r <= 1'b0;
      turn_r <= 2'd0;
      tx_idx_r <= 5'd0;
      tx_sum_r <= 8'h00;
      poll_served_out <= 1'b0;
    end else begin
      poll_served_out <= 1'b0;
      case (state_r)
        RMPL_S_LISTEN: begin
          if (accept_w) begin
            state_r <= RMPL_S_TURN;
            turn_r <= rmpl_pkg::TURN_TICKS;
            tx_idx_r <= 5'd0;
            tx_sum_r <= 8'h00;
          end
        end
        RMPL_S_TURN: begin // lets the master release its driver first
          if (tick_w) begin
            turn_r <= turn_r - 2'd1;
            if (turn_r == 2'd1) begin
              state_r <= RMPL_S_TALK;
              oe_r <= 1'b1;
            end
          end
        end
        RMPL_S_TALK: begin
          if (tx_load_w) begin
            tx_idx_r <= tx_idx_r + 5'd1;
            if (tx_idx_r >= rmpl_pkg::RSP_REQ_ADDR && tx_idx_r < rmpl_pkg::RSP_SUM) begin
              tx_sum_r <= tx_sum_r + tx_byte_w;
            end
          end else if (tx_bits_r == 4'h0) begin
            state_r <= RMPL_S_LISTEN;
            oe_r <= 1'b0;
            poll_served_out <= 1'b1;
          end
        end
        default: begin
          state_r <= RMPL_S_LISTEN;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign busy_out = (state_r != RMPL_S_LISTEN);
endmodule

//--- shared/rmpl_if.sv
// rs485 pair between the polling master and the sensor end
`timescale 1ns/1ps
interface rmpl_if;
  logic dev_tx;
  logic dev_oe;
  logic mst_tx;
  logic mst_oe;
  logic line;

  // idle line is the mark level; a clash shows the sensor's drive
  assign line = dev_oe ? dev_tx : (mst_oe ? mst_tx : 1'b1);

  modport sensor_mp (output dev_tx, output dev_oe, input line);
  modport master_mp (output mst_tx, output mst_oe, input line);
endinterface

//--- shared/rmpl_pkg.sv
// shared constants for the half-duplex measurement poll link
package rmpl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and bit timing
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_DEFAULT = 256_000;
  localparam int BAUD_MIN = 9_600;
  localparam int BAUD_MAX = 256_000;
  localparam int DIV_W = 12;
  // clocks per bit, rounded to nearest; 98 at the default rate
  localparam logic [11:0] DIV_DEFAULT = 12'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [11:0] DIV_MIN = 12'((CLK_HZ + BAUD_MAX / 2) / BAUD_MAX);
  localparam logic [11:0] DIV_MAX = 12'((CLK_HZ + BAUD_MIN / 2) / BAUD_MIN);
  localparam logic [3:0] UART_BITS = 4'd10;

  ////////////////////////////////////////////////////////////////////////
  // poll cycle time, kept in bit times so it scales with the rate
  localparam longint POLL_TIME_NS = 3_000_000;
  localparam int POLL_BITS = int'((POLL_TIME_NS * BAUD_DEFAULT) / 64'd1_000_000_000);
  // line turnaround before the sensor drives, in bit ticks
  localparam logic [1:0] TURN_TICKS = 2'd2;

  ////////////////////////////////////////////////////////////////////////
  // station addresses
  localparam logic [7:0] STATION_DEFAULT = 8'h7e;
  localparam logic [7:0] STATION_MIN = 8'h02;
  localparam logic [7:0] STATION_MAX = 8'h7e;

  ////////////////////////////////////////////////////////////////////////
  // frame bytes
  localparam logic [7:0] REQ_START = 8'h10;
  localparam logic [7:0] FUNC_MEAS = 8'h4c;
  localparam logic [7:0] FRAME_END = 8'h16;
  localparam logic [7:0] RSP_HDR = 8'h68;
  localparam logic [7:0] RSP_LEN = 8'h0b;
  localparam logic [7:0] RSP_CTRL = 8'h08;
  localparam logic [4:0] REQ_BYTES = 5'd6;
  localparam logic [4:0] RSP_BYTES = 5'd17;
  // zero-based response positions
  localparam logic [4:0] RSP_REQ_ADDR = 5'd4;
  localparam logic [4:0] RSP_OWN_ADDR = 5'd5;
  localparam logic [4:0] RSP_CTRL_POS = 5'd6;
  localparam logic [4:0] RSP_RAW0 = 5'd7;
  localparam logic [4:0] RSP_SCL0 = 5'd11;
  localparam logic [4:0] RSP_SUM = 5'd15;
  localparam logic [4:0] RSP_END = 5'd16;

endpackage

//--- sim/rmpl_link_properties.sv
// line-level checks on the joined master and sensor ends
`timescale 1ns/1ps
module rmpl_link_properties (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // interface signals
  input wire logic dev_tx,
  input wire logic dev_oe,
  input wire logic mst_tx,
  input wire logic mst_oe,
  input wire logic line
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////
  // low run lengths; every low run inside a frame is whole bit times
  logic [11:0] dev_low_r;
  logic [11:0] mst_low_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) dev_low_r <= 12'h000;
    else dev_low_r <= dev_tx ? 12'h000 : dev_low_r + 12'h001;
  end
  // same for the master drive
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) mst_low_r <= 12'h000;
    else mst_low_r <= mst_tx ? 12'h000 : mst_low_r + 12'h001;
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_dev_quiet;
    !dev_oe [*8];
  endsequence
  sequence s_mst_start;
    ##[0:2] !mst_tx;
  endsequence
  a_no_clash: assert property (!(dev_oe && mst_oe))
    else $error("both ends drive the line");
  a_dev_idle_mark: assert property (!dev_oe |-> dev_tx)
    else $error("sensor tx not idle high");
  a_mst_idle_mark: assert property (!mst_oe |-> mst_tx)
    else $error("master tx not idle high");
  a_dev_bit_time: assert property (dev_oe && $rose(dev_tx) |-> dev_low_r % rmpl_pkg::DIV_DEFAULT == 0)
    else $error("sensor low run not whole bit times");
  a_mst_bit_time: assert property (mst_oe && $rose(mst_tx) |-> mst_low_r % rmpl_pkg::DIV_DEFAULT == 0)
    else $error("master low run not whole bit times");
  a_dev_stop_end: assert property ($fell(dev_oe) |-> $past(dev_tx, 8))
    else $error("sensor released before stop bit");
  a_mst_stop_end: assert property ($fell(mst_oe) |-> $past(mst_tx, 8))
    else $error("master released before stop bit");
  a_turn_gap: assert property ($fell(mst_oe) |-> s_dev_quiet)
    else $error("sensor drove without turnaround");
  a_mst_frame_start: assert property ($rose(mst_oe) |-> s_mst_start)
    else $error("request frame did not open with start bit");
  a_dev_frame_start: assert property ($rose(dev_oe) |-> ##[0:200] !dev_tx)
    else $error("reply frame did not open with start bit");
  a_line_driven: assert property (mst_oe |-> line == mst_tx)
    else $error("line does not follow the master drive");
endmodule

//--- sim/rs485_measurement_poll_link_test.sv
// testbench: master and sensor ends joined, plus a sensor fed by hand
`timescale 1ns/1ps
module rs485_measurement_poll_link_test;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] baud_div = 12'h062;
  logic [7:0] station = 8'h7e;
  logic scale_set = 1'b1;
  logic [31:0] raw_val = 32'h0;
  logic [31:0] scl_val = 32'h0;
  logic poll_req = 1'b0;
  logic [7:0] tgt = 8'h0;
  logic [7:0] src = 8'h0;
  logic [31:0] raw_w, scl_w;
  logic rdy_w, valid_w, err_w, tmo_w, sum_err_b, busy_b, err_seen, acc_seen, drv;
  logic srv_w, srv_seen, clr;
  logic [7:0] b;
  logic [7:0] req_q[$];
  logic [7:0] rsp_q[$];
  int error_cnt = 0;
  int checks_done = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////////////////
  rmpl_if i_rmpl_if();
  rmpl_if i_rmpl_if_2();
  rmpl_sensor_end i_rmpl_sensor_end(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .link(i_rmpl_if.sensor_mp), .baud_div_in(baud_div), .station_in(station),
    .scale_set_in(scale_set), .raw_value_in(raw_val), .scaled_value_in(scl_val),
    .poll_served_out(srv_w), .sum_err_out(), .busy_out());
  rmpl_sensor_end i_rmpl_sensor_end_2(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .link(i_rmpl_if_2.sensor_mp), .baud_div_in(baud_div), .station_in(station),
    .scale_set_in(scale_set), .raw_value_in(raw_val), .scaled_value_in(scl_val),
    .poll_served_out(), .sum_err_out(sum_err_b), .busy_out(busy_b));
  rmpl_master_end #(.TIMEOUT_BITS(200)) i_rmpl_master_end(.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .link(i_rmpl_if.master_mp), .baud_div_in(baud_div),
    .poll_req_in(poll_req), .target_in(tgt), .source_in(src), .poll_ready_out(rdy_w),
    .raw_out(raw_w), .scaled_out(scl_w), .rsp_valid_out(valid_w), .rsp_err_out(err_w),
    .timeout_out(tmo_w));
  rmpl_link_properties i_rmpl_link_properties(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .dev_tx(i_rmpl_if.dev_tx), .dev_oe(i_rmpl_if.dev_oe), .mst_tx(i_rmpl_if.mst_tx),
    .mst_oe(i_rmpl_if.mst_oe), .line(i_rmpl_if.line));
  ////////////////////////////////////////////////////////////////////////
  // byte monitor on the joined line, mid-bit sampling, sorted by driver
  always begin
    @(negedge i_rmpl_if.line);
    drv = i_rmpl_if.dev_oe;
    repeat (49) @(posedge sys_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (98) @(posedge sys_clk_in);
      b[i] = i_rmpl_if.line;
    end
    repeat (98) @(posedge sys_clk_in);
    if (drv) rsp_q.push_back(b);
    else req_q.push_back(b);
  end
  // sticky flags; one writer, cleared by clr so no two processes race on them
  always @(posedge sys_clk_in) begin
    err_seen <= !clr && (err_seen || sum_err_b === 1'b1);
    acc_seen <= !clr && (acc_seen || busy_b === 1'b1 || i_rmpl_if_2.dev_oe === 1'b1);
    srv_seen <= !clr && (srv_seen || srv_w === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_q(input logic [7:0] g[$], input logic [7:0] e[$]);
    check(32'(g.size()), 32'(e.size()));
    for (int i = 0; i < e.size() && i < g.size(); i++) check({24'h0, g[i]}, {24'h0, e[i]});
  endtask
  // reply bytes worked out independently, sum over address through data
  task automatic check_reply(input logic [7:0] s, input logic [7:0] own,
                             input logic [31:0] r, input logic [31:0] c);
    logic [7:0] e[$];
    logic [7:0] sum;
    e = {8'h68, 8'h0b, 8'h0b, 8'h68, s, own, 8'h08, r[7:0], r[15:8], r[23:16], r[31:24],
         c[7:0], c[15:8], c[23:16], c[31:24]};
    sum = 8'h00;
    for (int i = 4; i < 15; i++) sum += e[i];
    e.push_back(sum);
    e.push_back(8'h16);
    cmp_q(rsp_q, e);
  endtask
  // one poll; result bits are timeout, error, valid; the wait is bounded
  task automatic do_poll(input logic [7:0] t, input logic [7:0] s, output logic [2:0] res);
    int n;
    res = 3'h0;
    n = 0;
    req_q.delete();
    rsp_q.delete();
    @(posedge sys_clk_in);
    check(32'(rdy_w), 32'h1);
    poll_req <= 1'b1;
    clr <= 1'b1;
    tgt <= t;
    src <= s;
    @(posedge sys_clk_in);
    poll_req <= 1'b0;
    clr <= 1'b0;
    while (res === 3'h0 && n < 40000) begin
      @(posedge sys_clk_in);
      #1;
      res = {tmo_w, err_w, valid_w};
      n++;
    end
    check(32'(n < 40000), 32'h1);
    if (n >= 40000) print_verdict();
    check(32'(n > 22000 && n < 75000), 32'h1);
    check(32'(rdy_w), 32'h1);
    repeat (300) @(posedge sys_clk_in);
  endtask
  // hand-driven 8N1 byte on the second line
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_in);
      i_rmpl_if_2.mst_tx <= f[i];
      repeat (97) @(posedge sys_clk_in);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_bad_sum();
    logic [7:0] fr[6];
    fr = '{8'h10, 8'h7e, 8'h01, 8'h4c, 8'h00, 8'h16};
    @(posedge sys_clk_in);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    i_rmpl_if_2.mst_oe <= 1'b1;
    foreach (fr[i]) send_byte(fr[i]);
    @(posedge sys_clk_in);
    i_rmpl_if_2.mst_oe <= 1'b0;
    repeat (600) @(posedge sys_clk_in);
    check(32'(err_seen), 32'h1);
    check(32'(acc_seen), 32'h0);
  endtask
  task automatic t_scaled();
    logic [2:0] res;
    station <= 8'h7e;
    scale_set <= 1'b1;
    raw_val <= 32'h3f6147ae;
    scl_val <= 32'h40490fdb;
    do_poll(8'h7e, 8'h01, res);
    check(32'(res), 32'h1);
    check(raw_w, 32'h3f6147ae);
    check(scl_w, 32'h40490fdb);
    check(32'(srv_seen), 32'h1);
    cmp_q(req_q, {8'h10, 8'h7e, 8'h01, 8'h4c, 8'hcb, 8'h16});
    check_reply(8'h01, 8'h7e, 32'h3f6147ae, 32'h40490fdb);
  endtask
  task automatic t_unscaled();
    logic [2:0] res;
    station <= 8'h05;
    scale_set <= 1'b0;
    raw_val <= 32'hc1200000;
    scl_val <= 32'h12345678;
    do_poll(8'h05, 8'h21, res);
    check(32'(res), 32'h1);
    check(scl_w, 32'h0);
    check(raw_w, 32'hc1200000);
    check_reply(8'h21, 8'h05, 32'hc1200000, 32'h0);
  endtask
  task automatic t_other();
    logic [2:0] res;
    station <= 8'h01;
    do_poll(8'h01, 8'h21, res);
    check(32'(res), 32'h4);
    check(32'(rsp_q.size()), 32'h0);
    check(32'(srv_seen), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_rmpl_if_2.mst_tx = 1'b1;
    i_rmpl_if_2.mst_oe = 1'b0;
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_bad_sum();
    t_scaled();
    t_unscaled();
    t_other();
    print_verdict();
  end
endmodule
